/* adcdof_pkg.sv */
// constants and types shared by the dual output formatter
// assumes every file imports it whole
package adcdof_pkg;
    // sample word width and lane counts
    localparam int WORD_W = 11;
    localparam int PAIR_N = 6;
    localparam int SWING_W = 4;
    localparam int MODE_W = 3;
    localparam int SYNC_N = 2;
    // full-scale codes, offset binary then twos complement
    localparam logic [10:0] OB_POS_FS = 11'h7FF;
    localparam logic [10:0] TC_POS_FS = 11'h3FF;
    localparam logic [10:0] OB_NEG_FS = 11'h000;
    localparam logic [10:0] TC_NEG_FS = 11'h400;
    // format bit value that selects twos complement
    localparam logic FMT_TWOS = 1'h1;
    // mode code that selects the multiplexed output, on field or pins
    localparam logic [2:0] MUX_MODE_CODE = 3'h6;
    // swing code after reset, nominal amplitude
    localparam logic [3:0] SWING_RESET = 4'h0;
    // reset values of the drive and output pins
    localparam logic DRIVE_RESET = 1'h0;
    localparam logic [10:0] PINS_RESET = 11'h000;
    // crossing word layout: second word, first word, then settings
    localparam int XW_SECOND = 0;
    localparam int XW_FIRST = 11;
    localparam int XW_SWING = 22;
    localparam int XW_CMOS = 26;
    localparam int XW_MUX = 27;
    localparam int XW_DDAT = 28;
    localparam int XW_DCLK = 29;
    localparam int XFER_W = 30;
    // link side sequencer, one-hot
    typedef enum logic [2:0] {
        LNK_IDLE = 3'h1,
        LNK_LOW = 3'h2,
        LNK_HIGH = 3'h4
    } adcdof_lnk_t;
endpackage

/* adcdof_code_if.sv */
// carrier between the top and the per-channel coders
// assumes one coder instance per channel index
`timescale 1ns/1ns
`default_nettype none
interface adcdof_code_if;
    import adcdof_pkg::*;
    logic [10:0] raw [2]; // offset binary conversion result
    logic overPos [2]; // positive overdrive flag
    logic overNeg [2]; // negative overdrive flag
    logic fmt [2]; // output code format per channel
    logic [10:0] coded [2]; // coded, clamped word
    modport coder (input raw, input overPos, input overNeg, input fmt, output coded);
    modport user (output raw, output overPos, output overNeg, output fmt, input coded);
endinterface
`default_nettype wire

/* adcdof_coder.sv */
// one channel's output coding and full-scale clamp
// assumes raw words arrive offset binary on the sampling clock
`timescale 1ns/1ns
`default_nettype none
module adcdof_coder
    import adcdof_pkg::*;
#(
    parameter int CH = 0
)(
    adcdof_code_if.coder cif
);
    // purely combinational: overdrive first, then format
    always_comb
    begin
        if (cif.overPos[CH])
        begin
            cif.coded[CH] = (cif.fmt[CH] == FMT_TWOS) ? TC_POS_FS : OB_POS_FS;
        end
        else if (cif.overNeg[CH])
        begin
            cif.coded[CH] = (cif.fmt[CH] == FMT_TWOS) ? TC_NEG_FS : OB_NEG_FS;
        end
        else if (cif.fmt[CH] == FMT_TWOS)
        begin
            // twos complement is offset binary with msb flipped
            cif.coded[CH] = {~cif.raw[CH][10], cif.raw[CH][9:0]};
        end
        else
        begin
            cif.coded[CH] = cif.raw[CH];
        end
    end
endmodule
`default_nettype wire

/* adcdof_xfer.sv */
// toggle handshake carrying one word from the sampling clock to the link clock
// assumes each side has its own synchronous reset and clock enable
`timescale 1ns/1ns
`default_nettype none
module adcdof_xfer
    import adcdof_pkg::*;
(
    input wire logic clkSrc,
    input wire logic rstSrc,
    input wire logic ceSrc,
    input wire logic [XFER_W-1:0] srcData,
    output logic srcReady,
    input wire logic clkDst,
    input wire logic rstDst,
    input wire logic ceDst,
    output logic [XFER_W-1:0] dstData,
    output logic dstFresh,
    input wire logic dstTake
);
    typedef struct packed {
        logic [XFER_W-1:0] data; // word held stable while in flight
        logic reqTgl; // flips once per word
        logic busy; // word not yet acknowledged
        logic [SYNC_N-1:0] ackSync; // ack toggle synchroniser
    } adcdof_xsrc_t;
    typedef struct packed {
        logic [XFER_W-1:0] data; // captured word
        logic fresh; // word waits for the link side
        logic ackTgl; // echo of the request toggle
        logic [SYNC_N-1:0] reqSync; // request toggle synchroniser
    } adcdof_xdst_t;
    adcdof_xsrc_t s_q;
    adcdof_xsrc_t s_d;
    adcdof_xdst_t d_q;
    adcdof_xdst_t d_d;

    // source side: load when idle, release once the ack returns
    always_comb
    begin
        s_d = s_q;
        s_d.ackSync = {s_q.ackSync[0], d_q.ackTgl};
        if (s_q.busy && (s_q.ackSync[1] == s_q.reqTgl))
        begin
            s_d.busy = 1'h0;
        end
        else if (!s_q.busy)
        begin
            s_d.data = srcData;
            s_d.reqTgl = ~s_q.reqTgl;
            s_d.busy = 1'h1;
        end
    end

    always_ff @(posedge clkSrc)
    begin
        if (rstSrc)
        begin
            s_q <= '0;
        end
        else if (ceSrc)
        begin
            s_q <= s_d;
        end
    end

    // destination side: capture only when the last word was taken
    always_comb
    begin
        d_d = d_q;
        d_d.reqSync = {d_q.reqSync[0], s_q.reqTgl};
        if (dstTake)
        begin
            d_d.fresh = 1'h0;
        end
        if ((d_q.reqSync[1] != d_q.ackTgl) && (!d_q.fresh || dstTake))
        begin
            // a new word beats the take in the same cycle
            d_d.data = s_q.data;
            d_d.fresh = 1'h1;
            d_d.ackTgl = d_q.reqSync[1];
        end
    end

    always_ff @(posedge clkDst)
    begin
        if (rstDst)
        begin
            d_q <= '0;
        end
        else if (ceDst)
        begin
            d_q <= d_d;
        end
    end

    assign srcReady = ~s_q.busy;
    assign dstData = d_q.data;
    assign dstFresh = d_q.fresh;
endmodule
`default_nettype wire

/* adcdof_formatter.sv */
// top of the dual output formatter: coding, crossing and link-side lanes
// assumes converter words arrive on clk_sys and the link clock runs free
// and that settings move only as levels written on clk_sys
`timescale 1ns/1ns
`default_nettype none
module adcdof_formatter
    import adcdof_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire logic [10:0] firstRaw,
    input wire logic [10:0] secondRaw,
    input wire logic firstOverPos,
    input wire logic firstOverNeg,
    input wire logic secondOverPos,
    input wire logic secondOverNeg,
    input wire logic [1:0] outputCodeFormat,
    input wire logic interfaceCmos,
    input wire logic [2:0] powerDownMode,
    input wire logic [2:0] ctrlPins,
    input wire logic [3:0] swingSelect,
    input wire logic dataDriveDouble,
    input wire logic clockDriveDouble,
    output logic forwardedOutputClock,
    output logic [10:0] firstChannelPins,
    output logic [10:0] secondChannelBus,
    output logic lvdsEnable,
    output logic muxActive,
    output logic [3:0] lvdsSwing,
    output logic dataDriveDoubleOut,
    output logic clockDriveDoubleOut
);
    // sampling clock side state
    typedef struct packed {
        logic [2:0] ctrlMeta; // first stage of the control pin synchroniser
        logic [2:0] ctrlSync; // control pins, safe to read
    } adcdof_sys_t;

    // link clock side state, all outputs come from here
    typedef struct packed {
        adcdof_lnk_t st; // phase sequencer
        logic fwdClk; // forwarded output clock
        logic [XFER_W-1:0] cur; // word and settings on the pins now
        logic [10:0] first; // first channel pins
        logic [10:0] second; // second channel bus
        logic lvdsOn; // differential buffers in use
        logic muxOn; // multiplexed arrangement in use
        logic [3:0] swing; // swing code to the buffers
        logic dDbl; // data buffers doubled
        logic cDbl; // clock buffer doubled
    } adcdof_lnk_st_t;

    adcdof_sys_t sy_q;
    adcdof_sys_t sy_d;
    adcdof_lnk_st_t ln_q;
    adcdof_lnk_st_t ln_d;

    logic [SYNC_N-1:0] linkRstSync; // reset carried into the link clock
    logic [SYNC_N-1:0] linkCeSync; // clock enable carried into the link clock
    logic linkRst; // link side synchronous reset
    logic linkCe; // link side clock enable
    logic muxSel; // mux selected by field or pins
    logic [XFER_W-1:0] srcWord; // word offered to the crossing
    logic [XFER_W-1:0] dstWord; // word waiting on the link side
    logic dstFresh; // waiting word not yet used
    logic take; // link side uses the waiting word

    adcdof_code_if cif ();

    // both channels share one coder shape
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_coder
            adcdof_coder #(
                .CH(ch)
            ) u_coder (
                .cif(cif)
            );
        end
    endgenerate

    // converter words and per channel format into the coders
    // overdrive flags reach the coders unregistered, alongside the raw words
    assign cif.raw[0] = firstRaw;
    assign cif.raw[1] = secondRaw;
    assign cif.overPos[0] = firstOverPos;
    assign cif.overPos[1] = secondOverPos;
    assign cif.overNeg[0] = firstOverNeg;
    assign cif.overNeg[1] = secondOverNeg;
    assign cif.fmt[0] = outputCodeFormat[0];
    assign cif.fmt[1] = outputCodeFormat[1];

    // control pins come from the board and are synchronised first
    always_comb
    begin
        sy_d = sy_q;
        sy_d.ctrlMeta = ctrlPins;
        sy_d.ctrlSync = sy_q.ctrlMeta;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sy_q <= '0;
        end
        else if (clkEn)
        begin
            sy_q <= sy_d;
        end
    end

    // either source may ask for the shared bus
    // the field shares this clock; only the pins needed the synchroniser
    assign muxSel = (powerDownMode == MUX_MODE_CODE) || (sy_q.ctrlSync == MUX_MODE_CODE);

    // words travel with their settings, so a change lands on a word boundary
    // the coders are combinational, so the snapshot holds this cycle's sample
    always_comb
    begin
        srcWord = '0;
        srcWord[XW_SECOND +: WORD_W] = cif.coded[1];
        srcWord[XW_FIRST +: WORD_W] = cif.coded[0];
        srcWord[XW_SWING +: SWING_W] = swingSelect;
        srcWord[XW_CMOS] = interfaceCmos;
        srcWord[XW_MUX] = muxSel;
        srcWord[XW_DDAT] = dataDriveDouble;
        srcWord[XW_DCLK] = clockDriveDouble;
    end

    // one word in flight at a time; samples in between are dropped
    adcdof_xfer u_xfer (
        .clkSrc(clk_sys),
        .rstSrc(sys_rst),
        .ceSrc(clkEn),
        .srcData(srcWord),
        .srcReady(), // words are paced by the link side, readiness is not needed
        .clkDst(linkClk),
        .rstDst(linkRst),
        .ceDst(linkCe),
        .dstData(dstWord),
        .dstFresh(dstFresh),
        .dstTake(take)
    );

    // reset and enable bridges into the link clock, never frozen themselves
    // plain two stage bridges suffice: both are slow levels, not pulses
    always_ff @(posedge linkClk)
    begin
        linkRstSync <= {linkRstSync[0], sys_rst};
        linkCeSync <= {linkCeSync[0], clkEn};
    end

    assign linkRst = linkRstSync[1];
    assign linkCe = linkCeSync[1];

    // pin values for one half period of the forwarded clock
    // mux mode wins over the interface bit, then parallel, then differential
    function automatic logic [21:0] laneOut(input logic [XFER_W-1:0] w, input logic high);
        logic [10:0] a;
        logic [10:0] b;
        logic [11:0] aw;
        logic [11:0] bw;
        logic [10:0] fo;
        logic [10:0] so;
        a = w[XW_FIRST +: WORD_W];
        b = w[XW_SECOND +: WORD_W];
        aw = {1'h0, a};
        bw = {1'h0, b};
        fo = PINS_RESET;
        so = PINS_RESET;
        if (w[XW_MUX])
        begin
            // low half first channel, high half second channel
            fo = PINS_RESET;
            so = high ? b : a;
        end
        else if (w[XW_CMOS])
        begin
            // full word on its own pins, stable over the clock period
            fo = a;
            so = b;
        end
        else
        begin
            // pair k carries bit 2k on the low half, 2k+1 on the high half
            for (int k = 0; k < PAIR_N; k++)
            begin
                fo[k] = high ? aw[2*k+1] : aw[2*k];
                so[k] = high ? bw[2*k+1] : bw[2*k];
            end
        end
        return {fo, so};
    endfunction

    // two link cycles make one forwarded clock period, a word per period
    always_comb
    begin
        ln_d = ln_q;
        take = 1'h0;
        if (linkCe)
        begin
            case (ln_q.st)
                LNK_IDLE:
                begin
                    // clock held low until the first word arrives
                    if (dstFresh)
                    begin
                        take = 1'h1;
                        ln_d.cur = dstWord;
                        ln_d.st = LNK_LOW;
                        ln_d.fwdClk = 1'h0;
                    end
                end
                LNK_LOW:
                begin
                    // rising edge sits mid-word for parallel capture
                    ln_d.st = LNK_HIGH;
                    ln_d.fwdClk = 1'h1;
                end
                LNK_HIGH:
                begin
                    // falling edge starts the next word, else repeat the last
                    ln_d.st = LNK_LOW;
                    ln_d.fwdClk = 1'h0;
                    if (dstFresh)
                    begin
                        take = 1'h1;
                        ln_d.cur = dstWord;
                    end
                end
                default:
                begin
                    ln_d.st = LNK_IDLE;
                end
            endcase
            if (ln_d.st != LNK_IDLE)
            begin
                {ln_d.first, ln_d.second} = laneOut(ln_d.cur, ln_d.fwdClk);
                ln_d.muxOn = ln_d.cur[XW_MUX];
                ln_d.lvdsOn = ~ln_d.cur[XW_CMOS] & ~ln_d.cur[XW_MUX];
                ln_d.swing = ln_d.cur[XW_SWING +: SWING_W];
                ln_d.dDbl = ln_d.cur[XW_DDAT];
                ln_d.cDbl = ln_d.cur[XW_DCLK];
            end
        end
    end

    // link side register, default strength and nominal swing at reset
    // a freeze keeps ln_d equal to ln_q, so no enable is needed here
    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            ln_q.st <= LNK_IDLE;
            ln_q.fwdClk <= 1'h0;
            ln_q.cur <= '0;
            ln_q.first <= PINS_RESET;
            ln_q.second <= PINS_RESET;
            ln_q.lvdsOn <= 1'h1;
            ln_q.muxOn <= 1'h0;
            ln_q.swing <= SWING_RESET;
            ln_q.dDbl <= DRIVE_RESET;
            ln_q.cDbl <= DRIVE_RESET;
        end
        else
        begin
            ln_q <= ln_d;
        end
    end

    // every output straight from the link side register
    // nothing combinational sits between these registers and the pins
    assign forwardedOutputClock = ln_q.fwdClk;
    assign firstChannelPins = ln_q.first;
    assign secondChannelBus = ln_q.second;
    assign lvdsEnable = ln_q.lvdsOn;
    assign muxActive = ln_q.muxOn;
    assign lvdsSwing = ln_q.swing;
    assign dataDriveDoubleOut = ln_q.dDbl;
    assign clockDriveDoubleOut = ln_q.cDbl;
endmodule
`default_nettype wire

/* adcdof_formatter_monitor.sv */
// assertions on the formatter's link-side outputs
// assumes binding onto adcdof_formatter, link reset follows sys_rst
`timescale 1ns/1ns
`default_nettype none
module adcdof_formatter_monitor
    import adcdof_pkg::*;
(
    input wire logic linkClk,
    input wire logic sys_rst,
    input wire logic forwardedOutputClock,
    input wire logic [10:0] firstChannelPins,
    input wire logic [10:0] secondChannelBus,
    input wire logic lvdsEnable,
    input wire logic muxActive,
    input wire logic [3:0] lvdsSwing,
    input wire logic dataDriveDoubleOut,
    input wire logic clockDriveDoubleOut
);
    // all checks sample on the link clock; all but reset_default_a rest during reset
    default clocking @(posedge linkClk); endclocking
    default disable iff (sys_rst);

    mux_first_low_a: assert property (muxActive |-> firstChannelPins == PINS_RESET)
        else $error("first pins not low in mux mode");
    mux_single_ended_a: assert property (muxActive |-> !lvdsEnable)
        else $error("differential lanes left on in mux mode");
    ddr_upper_zero_a: assert property (lvdsEnable |-> firstChannelPins[10:6] == 5'h00
        && secondChannelBus[10:6] == 5'h00) else $error("unused pair lanes driven");
    clock_half_rate_a: assert property ($rose(forwardedOutputClock) |=> $fell(forwardedOutputClock))
        else $error("forwarded clock high for more than one link cycle");
    parallel_steady_a: assert property ($rose(forwardedOutputClock) && !lvdsEnable && !muxActive
        |-> $stable(firstChannelPins) && $stable(secondChannelBus)) else $error("parallel word moved mid period");
    swing_hold_a: assert property (forwardedOutputClock |-> $stable(lvdsSwing))
        else $error("swing changed inside a word");
    drive_hold_a: assert property (forwardedOutputClock |-> $stable({dataDriveDoubleOut, clockDriveDoubleOut}))
        else $error("drive doubling changed inside a word");
    reset_default_a: assert property (disable iff (1'b0) sys_rst [*5] |-> !forwardedOutputClock && lvdsEnable
        && !muxActive && lvdsSwing == SWING_RESET && !dataDriveDoubleOut && !clockDriveDoubleOut)
        else $error("outputs not at defaults in reset");

    // main scenarios reached
    cover property ($rose(muxActive));
    cover property (lvdsEnable && $rose(forwardedOutputClock));
    cover property ($rose(dataDriveDoubleOut));
    cover property (!lvdsEnable && !muxActive && $rose(forwardedOutputClock));
endmodule

bind adcdof_formatter adcdof_formatter_monitor adcdof_formatter_monitor_i (.linkClk, .sys_rst,
    .forwardedOutputClock, .firstChannelPins, .secondChannelBus, .lvdsEnable, .muxActive, .lvdsSwing,
    .dataDriveDoubleOut, .clockDriveDoubleOut);
`default_nettype wire

/* adcdof_receiver.sv */
// capture model of the logic receiving the formatter's lanes
// assumes lanes move only on link clock rising edges
`timescale 1ns/1ns
`default_nettype none
module adcdof_receiver
    import adcdof_pkg::*;
(
    input wire logic linkClk,
    input wire logic forwardedOutputClock,
    input wire logic [10:0] firstChannelPins,
    input wire logic [10:0] secondChannelBus,
    input wire logic lvdsEnable,
    input wire logic muxActive,
    output logic [10:0] rxFirst,
    output logic [10:0] rxSecond
);
    logic [10:0] lowFirst; // lanes held while the clock was low
    logic [10:0] lowSecond;

    // rebuild a word from the two halves of each pair
    function automatic logic [10:0] unpair(input logic [10:0] lo, input logic [10:0] hi);
        logic [11:0] w;
        for (int k = 0; k < PAIR_N; k++)
        begin
            w[2*k] = lo[k];
            w[2*k+1] = hi[k];
        end
        return w[10:0];
    endfunction

    // sample mid half on the link clock, a delayed copy of the input clock
    always @(negedge linkClk)
    begin
        if (forwardedOutputClock === 1'b0)
        begin
            lowFirst <= firstChannelPins;
            lowSecond <= secondChannelBus;
        end
        else if (muxActive)
        begin
            rxFirst <= lowSecond;
            rxSecond <= secondChannelBus;
        end
        else if (lvdsEnable)
        begin
            rxFirst <= unpair(lowFirst, firstChannelPins);
            rxSecond <= unpair(lowSecond, secondChannelBus);
        end
        else
        begin
            rxFirst <= firstChannelPins;
            rxSecond <= secondChannelBus;
        end
    end
endmodule
`default_nettype wire

/* adcdof_formatter_test.sv */
// self-checking bench for the dual output formatter
// assumes the receiver model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module adcdof_formatter_test;
    import adcdof_pkg::*;
    logic clk_sys = 1'b0, linkClk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1;
    logic [10:0] firstRaw = 11'h000, secondRaw = 11'h000;
    logic firstOverPos = 1'b0, firstOverNeg = 1'b0, secondOverPos = 1'b0, secondOverNeg = 1'b0;
    logic [1:0] outputCodeFormat = 2'h0;
    logic interfaceCmos = 1'b0, dataDriveDouble = 1'b0, clockDriveDouble = 1'b0;
    logic [2:0] powerDownMode = 3'h0, ctrlPins = 3'h0;
    logic [3:0] swingSelect = 4'h0, lvdsSwing;
    logic forwardedOutputClock, lvdsEnable, muxActive, dataDriveDoubleOut, clockDriveDoubleOut;
    logic [10:0] firstChannelPins, secondChannelBus, rxFirst, rxSecond;
    logic [31:0] seed = 32'h0a24_de99; // xorshift state
    int failCount = 0; // mismatches
    int numChecks = 0; // comparisons made

    adcdof_formatter adcdof_formatter_i (.clk_sys, .sys_rst, .clkEn, .linkClk, .firstRaw, .secondRaw,
        .firstOverPos, .firstOverNeg, .secondOverPos, .secondOverNeg, .outputCodeFormat, .interfaceCmos,
        .powerDownMode, .ctrlPins, .swingSelect, .dataDriveDouble, .clockDriveDouble, .forwardedOutputClock,
        .firstChannelPins, .secondChannelBus, .lvdsEnable, .muxActive, .lvdsSwing, .dataDriveDoubleOut,
        .clockDriveDoubleOut);
    adcdof_receiver adcdof_receiver_i (.linkClk, .forwardedOutputClock, .firstChannelPins,
        .secondChannelBus, .lvdsEnable, .muxActive, .rxFirst, .rxSecond);

    // sampling clock, 8 ns
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    // link clock, 125 ns, offset in phase
    initial
    begin
        #3;
        forever
        begin
            #62 linkClk = ~linkClk;
            #63 linkClk = ~linkClk;
        end
    end

    // xorshift source of random stimulus
    function automatic logic [31:0] nextRand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // reference coding of one channel word
    function automatic int code(int raw, int fmt, int pos, int neg);
        if (pos) return fmt ? 1023 : 2047;
        if (neg) return fmt ? 1024 : 0;
        return fmt ? (raw + 1024) % 2048 : raw;
    endfunction

    // compare a data word
    task automatic check_word(input string what, input logic [10:0] exp, input logic [10:0] seen);
        numChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // compare a setting or flag
    task automatic check_setting(input string what, input logic [3:0] exp, input logic [3:0] seen);
        numChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // counts, verdict and end of run
    task printVerdict();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence: every mode, format pair and overdrive case
    initial
    begin
        logic [31:0] r;
        int mode;
        logic [10:0] expFirst;
        logic [10:0] expSecond;
        repeat (96) @(posedge clk_sys); // spans six link edges, so the link side sees reset too
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            r = nextRand();
            mode = i % 4; // 0 ddr, 1 parallel, 2 mux by field, 3 mux by pins
            @(posedge clk_sys);
            firstRaw <= r[10:0];
            secondRaw <= r[21:11];
            firstOverPos <= (i % 3 == 1);
            firstOverNeg <= (i % 3 == 2);
            secondOverPos <= (i % 3 == 2);
            secondOverNeg <= (i % 3 == 0);
            outputCodeFormat <= 2'(i / 4);
            swingSelect <= r[25:22];
            dataDriveDouble <= r[26];
            clockDriveDouble <= r[27];
            interfaceCmos <= (mode == 1) || (mode >= 2 && r[28]);
            powerDownMode <= (mode == 2) ? MUX_MODE_CODE : 3'(r[31:29] % 6);
            ctrlPins <= (mode == 3) ? MUX_MODE_CODE : 3'(r[4:2] % 6);
            repeat (625) @(posedge clk_sys); // forty link cycles to settle
            expFirst = 11'(code(firstRaw, outputCodeFormat[0], firstOverPos, firstOverNeg));
            expSecond = 11'(code(secondRaw, outputCodeFormat[1], secondOverPos, secondOverNeg));
            check_word("first word", expFirst, rxFirst);
            check_word("second word", expSecond, rxSecond);
            check_setting("mux flag", {3'h0, mode >= 2}, {3'h0, muxActive});
            check_setting("lvds flag", {3'h0, mode == 0}, {3'h0, lvdsEnable});
            check_setting("swing", swingSelect, lvdsSwing);
            check_setting("data drive", {3'h0, dataDriveDouble}, {3'h0, dataDriveDoubleOut});
            check_setting("clock drive", {3'h0, clockDriveDouble}, {3'h0, clockDriveDoubleOut});
            $display("test %0d mode %0d done", i, mode);
        end
        printVerdict();
    end

    // cuts a hang short well past the expected 81 us
    initial
    begin
        #200000;
        failCount++;
        printVerdict();
    end
endmodule
`default_nettype wire
